// file: design/serial_tx_pkg.sv
// constants and carrier types for the asynchronous serial transmitter
package serial_tx_pkg;

    // register byte addresses
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam logic [3:0] ADDR_BAUD = 4'hc;

    // field layout
    localparam int CTRL_WIDTH = 6;
    localparam int DIV_WIDTH  = 13;
    localparam int FRAME_BITS = 11;

    // values after reset
    localparam logic [12:0] BAUD_RESET = 13'h0001;
    localparam logic        TRANSMIT_BUFFER_EMPTY_FLAG_RESET = 1'b1;
    localparam logic        TC_RESET   = 1'b1;

    // frame lengths in bit times
    localparam logic [3:0] LEN_8BIT  = 4'ha;
    localparam logic [3:0] LEN_9BIT  = 4'hb;
    localparam logic [3:0] LEN_BRK   = 4'ha;
    localparam logic [3:0] LEN_BRK9  = 4'hb;
    localparam logic [3:0] LEN_LBRK  = 4'hd;
    localparam logic [3:0] LEN_LBRK9 = 4'he;

    // oversampling: last phase of sixteen
    localparam logic [3:0] PHASE_LAST = 4'hf;

    // control register, bit 5 first
    typedef struct packed {
        logic ninth_transmit_bit;
        logic transmit_polarity_invert;
        logic nine_bit_mode;
        logic long_break_select;
        logic send_break_control;
        logic transmitter_enable;
    } ctrl_t;

endpackage

// file: design/baud_divider.sv
// modulo divider giving sample and bit tick enables
`timescale 1ns/1ps
module baud_divider (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // divisor, zero stops the generator
    input  wire logic [12:0] divisor,
    // tick enables
    output logic             os_tick,
    output logic             bit_tick
);
    logic [12:0] count;
    logic [3:0]  phase;
    wire         wrap = (count >= divisor - 13'h0001);

    // bus clock over divisor, then over sixteen
    always_ff @(posedge core_clk) begin
        if (reset || divisor == 13'h0000) begin
            count    <= 13'h0000;
            phase    <= 4'h0;
            os_tick  <= 1'b0;
            bit_tick <= 1'b0;
        end else if (wrap) begin
            count    <= 13'h0000;
            phase    <= phase + 4'h1;
            os_tick  <= 1'b1;
            bit_tick <= (phase == serial_tx_pkg::PHASE_LAST);
        end else begin
            count    <= count + 13'h0001;
            os_tick  <= 1'b0;
            bit_tick <= 1'b0;
        end
    end
endmodule

// file: design/frame_shifter.sv
// transmit shift register, one bit per bit tick
`timescale 1ns/1ps
module frame_shifter (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        bit_tick,
    // frame load
    input  wire logic        load,
    input  wire logic [10:0] frame,
    input  wire logic        fill,
    input  wire logic [3:0]  length,
    // line and state
    output logic             line,
    output logic             busy,
    output logic             free_now
);
    logic [10:0] sr;
    logic [3:0]  count;
    logic        fill_q;

    // free during the last bit, so frames follow back to back
    assign free_now = !busy || count == 4'h1;

    // fill bit carries breaks past the eleven stored bits
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sr     <= 11'h7ff;
            count  <= 4'h0;
            fill_q <= 1'b1;
            line   <= 1'b1;
            busy   <= 1'b0;
        end else if (bit_tick && load) begin
            line   <= frame[0];
            sr     <= {fill, frame[10:1]};
            fill_q <= fill;
            count  <= length;
            busy   <= 1'b1;
        end else if (bit_tick && busy) begin
            if (count == 4'h1) begin
                busy <= 1'b0;
                line <= 1'b1;
            end else begin
                line  <= sr[0];
                sr    <= {fill_q, sr[10:1]};
                count <= count - 4'h1;
            end
        end
    end
endmodule

// file: design/async_serial_transmitter.sv
// transmitter top: avalon registers, frame control, pin
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module async_serial_transmitter (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // receive side hookup
    input  wire logic [7:0]  rx_buffer_data,
    input  wire logic        rx_pin,
    output logic             rx_data_read,
    output logic             rx_edge_align,
    output logic             rx_sample_tick,
    // transmit pin
    output logic             tx_out,
    output logic             tx_oe
);
    typedef enum logic [1:0] {
        K_NONE,
        K_DATA,
        K_BREAK,
        K_IDLE
    } kind_t;

    serial_tx_pkg::ctrl_t ctrl;
    logic [12:0] divisor;
    logic [7:0]  tx_buf;
    logic        tx_ninth;
    logic        transmit_buffer_empty_flag;
    logic        transmit_complete_flag;
    logic        transmit_buffer_empty_flag_armed;
    logic        tc_armed;
    logic        owned;
    logic        break_q;
    logic        idle_q;
    kind_t       kind_q;
    logic        wait_q;
    logic        rx_meta;
    logic        rx_sync;
    logic        rx_prev;

    // baud generator and shifter wires
    logic        os_tick;
    logic        bit_tick;
    logic        shifter_line;
    logic        shifter_busy;
    logic        shifter_free;

    // one generator serves both directions
    baud_divider u_baud (
        .core_clk (core_clk),
        .reset    (reset),
        .divisor  (divisor),
        .os_tick  (os_tick),
        .bit_tick (bit_tick)
    );

    // bus handshake decode
    wire req     = read | write;
    wire rd_done = read & ~wait_q;
    wire wr_done = write & ~wait_q;
    wire sel_data = (address == serial_tx_pkg::ADDR_DATA);
    wire sel_ctrl = (address == serial_tx_pkg::ADDR_CTRL);
    wire sel_stat = (address == serial_tx_pkg::ADDR_STAT);
    wire sel_baud = (address == serial_tx_pkg::ADDR_BAUD);

    // write strobes per register and lane
    wire wr_data    = wr_done & sel_data & byteenable[0];
    wire wr_ctrl    = wr_done & sel_ctrl & byteenable[0];
    wire wr_baud_lo = wr_done & sel_baud & byteenable[0];
    wire wr_baud_hi = wr_done & sel_baud & byteenable[1];

    // incoming control value
    serial_tx_pkg::ctrl_t new_ctrl;
    assign new_ctrl = serial_tx_pkg::ctrl_t'(
        writedata[serial_tx_pkg::CTRL_WIDTH-1:0]);

    // enable and break edges seen on control writes
    wire te_rise  = wr_ctrl & new_ctrl.transmitter_enable
                  & ~ctrl.transmitter_enable;
    wire sbk_fall = wr_ctrl & ~new_ctrl.send_break_control
                  & ctrl.send_break_control
                  & ctrl.transmitter_enable;

    // slot for a new frame, chosen by priority
    wire slot       = bit_tick & shifter_free;
    wire pick_idle  = slot & idle_q;
    wire pick_break = slot & ~idle_q & break_q;
    wire pick_data  = slot & ~idle_q & ~break_q
                    & ~transmit_buffer_empty_flag
                    & ctrl.transmitter_enable;
    wire pick_none  = slot & ~idle_q & ~break_q & ~pick_data;
    wire load       = pick_idle | pick_break | pick_data;
    wire tc_set     = pick_none & shifter_busy;
    wire release_pin = pick_none & ~ctrl.transmitter_enable;

    // break length table
    wire [3:0] brk_len = ctrl.long_break_select
        ? (ctrl.nine_bit_mode ? serial_tx_pkg::LEN_LBRK9
                              : serial_tx_pkg::LEN_LBRK)
        : (ctrl.nine_bit_mode ? serial_tx_pkg::LEN_BRK9
                              : serial_tx_pkg::LEN_BRK);

    // ten or eleven bit character
    wire [3:0] chr_len = ctrl.nine_bit_mode
        ? serial_tx_pkg::LEN_9BIT : serial_tx_pkg::LEN_8BIT;

    // start, data, optional ninth bit, stop
    wire [10:0] data_frame = ctrl.nine_bit_mode
        ? {1'b1, tx_ninth, tx_buf, 1'b0}
        : {1'b1, 1'b1, tx_buf, 1'b0};

    // frame selection; break is all zero with zero fill
    wire [10:0] load_frame = pick_break ? 11'h000
                           : pick_idle  ? 11'h7ff
                           : data_frame;
    wire        load_fill  = ~pick_break;
    wire [3:0]  load_len   = pick_break ? brk_len : chr_len;

    frame_shifter u_shift (
        .core_clk (core_clk),
        .reset    (reset),
        .bit_tick (bit_tick),
        .load     (load),
        .frame    (load_frame),
        .fill     (load_fill),
        .length   (load_len),
        .line     (shifter_line),
        .busy     (shifter_busy),
        .free_now (shifter_free)
    );

    // status word: empty, complete, pin held
    wire [31:0] stat_word = {29'h0, owned,
                             transmit_complete_flag,
                             transmit_buffer_empty_flag};

    // reads of data address return the receive buffer
    wire [31:0] next_readdata =
          sel_data ? {24'h0, rx_buffer_data}
        : sel_ctrl ? {26'h0, ctrl}
        : sel_stat ? stat_word
        : sel_baud ? {19'h0, divisor}
        : 32'h0;

    // one wait state, answer on the second cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wait_q   <= 1'b1;
            readdata <= 32'h0;
        end else if (req && wait_q) begin
            wait_q   <= 1'b0;
            readdata <= next_readdata;
        end else begin
            wait_q   <= 1'b1;
        end
    end
    assign waitrequest = wait_q;

    // software registers; data write keeps ninth bit too
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl     <= '0;
            divisor  <= serial_tx_pkg::BAUD_RESET;
            tx_buf   <= 8'h00;
            tx_ninth <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= new_ctrl;
            end
            if (wr_baud_lo) begin
                divisor[7:0] <= writedata[7:0];
            end
            if (wr_baud_hi) begin
                divisor[12:8] <= writedata[12:8];
            end
            if (wr_data) begin
                tx_buf   <= writedata[7:0];
                tx_ninth <= ctrl.ninth_transmit_bit;
            end
        end
    end

    // status read with flag set arms the clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            transmit_buffer_empty_flag_armed <= 1'b0;
            tc_armed   <= 1'b0;
        end else if (rd_done && sel_stat) begin
            transmit_buffer_empty_flag_armed <= readdata[0];
            tc_armed   <= readdata[1];
        end else if (wr_data) begin
            transmit_buffer_empty_flag_armed <= 1'b0;
            tc_armed   <= 1'b0;
        end
    end

    // empty flag: set on load wins over the data write
    always_ff @(posedge core_clk) begin
        if (reset) begin
            transmit_buffer_empty_flag <= serial_tx_pkg::TRANSMIT_BUFFER_EMPTY_FLAG_RESET;
        end else if (pick_data) begin
            transmit_buffer_empty_flag <= 1'b1;
        end else if (wr_data && transmit_buffer_empty_flag_armed) begin
            transmit_buffer_empty_flag <= 1'b0;
        end
    end

    // complete flag; queuing a frame also clears it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            transmit_complete_flag <= serial_tx_pkg::TC_RESET;
        end else if (tc_set) begin
            transmit_complete_flag <= 1'b1;
        end else if ((wr_data && tc_armed) || te_rise || sbk_fall) begin
            transmit_complete_flag <= 1'b0;
        end
    end

    // queued idle covers the preamble and the toggle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            idle_q <= 1'b0;
        end else if (te_rise) begin
            idle_q <= 1'b1;
        end else if (pick_idle) begin
            idle_q <= 1'b0;
        end
    end

    // break queue: falling control queues, held control requeues
    always_ff @(posedge core_clk) begin
        if (reset) begin
            break_q <= 1'b0;
        end else if (sbk_fall) begin
            break_q <= 1'b1;
        end else if (pick_break) begin
            break_q <= ctrl.send_break_control;
        end
    end

    // pin kept until shifter and queues drain
    always_ff @(posedge core_clk) begin
        if (reset) begin
            owned <= 1'b0;
        end else if (te_rise) begin
            owned <= 1'b1;
        end else if (release_pin) begin
            owned <= 1'b0;
        end
    end

    // kind of frame in the shifter, for the break check
    always_ff @(posedge core_clk) begin
        if (reset) begin
            kind_q <= K_NONE;
        end else if (pick_idle) begin
            kind_q <= K_IDLE;
        end else if (pick_break) begin
            kind_q <= K_BREAK;
        end else if (pick_data) begin
            kind_q <= K_DATA;
        end else if (pick_none) begin
            kind_q <= K_NONE;
        end
    end

    // pin: idle high, inverted for every element
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_out <= 1'b1;
            tx_oe  <= 1'b0;
        end else begin
            tx_out <= shifter_line ^ ctrl.transmit_polarity_invert;
            tx_oe  <= owned;
        end
    end

    // receive line sync; second stage feeds the edge detect
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // receive side pulses: realign, sample tick, data read
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_edge_align  <= 1'b0;
            rx_sample_tick <= 1'b0;
            rx_data_read   <= 1'b0;
        end else begin
            rx_edge_align  <= rx_prev & ~rx_sync;
            rx_sample_tick <= os_tick;
            rx_data_read   <= rd_done & sel_data;
        end
    end

    // checks on the block's own behaviour
    localparam int ANSWER_MAX = 1;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence data_read_req;
        read && wait_q && sel_data;
    endsequence

    sequence armed_data_write;
        transmit_buffer_empty_flag_armed && wr_data && !pick_data;
    endsequence

    sequence break_in_shifter;
        kind_q == K_BREAK && shifter_busy && owned;
    endsequence

    bus_answer_a: assert property (
        req && waitrequest |-> ##[1:ANSWER_MAX] !waitrequest)
        else $error("bus answer late");

    data_read_map_a: assert property (
        data_read_req |=> readdata[7:0] == $past(rx_buffer_data))
        else $error("data read not from receive buffer");

    flag_clear_seq_a: assert property (
        armed_data_write |=> !transmit_buffer_empty_flag)
        else $error("empty flag not cleared by sequence");

    shared_tick_a: assert property (
        $rose(bit_tick) |=> rx_sample_tick)
        else $error("bit tick without sample tick");

    edge_align_a: assert property (
        $fell(rx_sync) |=> rx_edge_align)
        else $error("falling edge not realigned");

    idle_level_a: assert property (
        !shifter_busy ##1 !shifter_busy |->
        tx_out == $past(ctrl.transmit_polarity_invert) ^ 1'b1)
        else $error("idle level wrong");

    preamble_a: assert property (
        te_rise |=> idle_q && owned)
        else $error("no preamble queued on enable");

    transmit_buffer_empty_flag_set_a: assert property (
        pick_data |=> transmit_buffer_empty_flag && shifter_busy)
        else $error("load did not set empty flag");

    tc_set_a: assert property (
        tc_set |=> transmit_complete_flag ##1 tx_out ==
        ($past(ctrl.transmit_polarity_invert, 2) ^ 1'b1))
        else $error("complete flag or idle line missing");

    pin_hold_a: assert property (
        owned && (!shifter_free || idle_q || break_q) |=> owned)
        else $error("pin released early");

    break_requeue_a: assert property (
        pick_break && ctrl.send_break_control |=> break_q)
        else $error("break not requeued");

    break_low_a: assert property (
        break_in_shifter |=>
        tx_out == $past(ctrl.transmit_polarity_invert))
        else $error("break not at space level");

    idle_toggle_a: assert property (
        te_rise && owned |=> idle_q ##0 owned)
        else $error("toggle did not queue idle");

endmodule

// file: tb/serial_rx_model.sv
// remote receiver model watching the transmit line
`timescale 1ns/1ps
module serial_rx_model (
    // clock
    input  wire logic core_clk,
    // line and framing setup
    input  wire logic line_in,
    input  wire logic invert,
    input  wire logic nine,
    // received results
    output logic [8:0] rx_word,
    output logic       rx_fe,
    output int         rx_count,
    output int         low_len
);
    logic lvl;
    int   run = 0;

    // undo polarity so one sampler serves both senses
    assign lvl = line_in ^ invert;

    // length of each low stretch in core_clk cycles
    always @(posedge core_clk) begin
        if (lvl === 1'b1) begin
            if (run != 0)
                low_len <= run;
            run <= 0;
        end else if (lvl === 1'b0) begin
            run <= run + 1;
        end
    end

    // mid-bit sampler, same rate as sender, resync on each start
    initial begin
        rx_count = 0;
        rx_fe    = 1'b0;
        rx_word  = 9'h000;
        forever begin
            @(posedge core_clk iff lvl === 1'b0);
            repeat (8) @(posedge core_clk);
            // short glitches are not start bits
            if (lvl !== 1'b0)
                continue;
            rx_word = 9'h000;
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (16) @(posedge core_clk);
                rx_word[i] = lvl;
            end
            repeat (16) @(posedge core_clk);
            rx_fe = (lvl !== 1'b1);
            rx_count++;
            @(posedge core_clk iff lvl === 1'b1);
        end
    end
endmodule

// file: tb/async_serial_transmitter_tb_top.sv
// self-checking bench for the asynchronous serial transmitter
`timescale 1ns/1ps
module async_serial_transmitter_tb_top;
    localparam logic [3:0]  A_DAT = serial_tx_pkg::ADDR_DATA;
    localparam logic [3:0]  A_CTL = serial_tx_pkg::ADDR_CTRL;
    localparam logic [3:0]  A_STA = serial_tx_pkg::ADDR_STAT;
    localparam logic [3:0]  A_BAU = serial_tx_pkg::ADDR_BAUD;
    localparam logic [31:0] EN    = 32'h00000001;
    localparam logic [31:0] SEND_BREAK_CONTROL   = 32'h00000002;
    localparam logic [31:0] LBRK  = 32'h00000004;
    localparam logic [31:0] NINE  = 32'h00000008;
    localparam logic [31:0] INV   = 32'h00000010;
    localparam logic [31:0] T8    = 32'h00000020;

    logic        core_clk, reset, read, write;
    logic [3:0]  address, byteenable;
    logic [31:0] writedata, readdata, q;
    logic        waitrequest, rx_pin, rx_data_read;
    logic        rx_edge_align, rx_sample_tick, tx_out, tx_oe;
    logic [7:0]  rx_buffer_data;
    logic        inv, nine, rx_fe;
    logic [8:0]  rx_word;
    int          rx_count, low_len, error_cnt, check_count, cyc;
    logic        pin_line;

    // released pin parked as a high output by software
    assign pin_line = tx_oe ? tx_out : 1'b1;

    async_serial_transmitter async_serial_transmitter_inst (
        .core_clk(core_clk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .rx_buffer_data(rx_buffer_data),
        .rx_pin(rx_pin), .rx_data_read(rx_data_read),
        .rx_edge_align(rx_edge_align), .rx_sample_tick(rx_sample_tick),
        .tx_out(tx_out), .tx_oe(tx_oe));

    serial_rx_model serial_rx_model_inst (
        .core_clk(core_clk), .line_in(pin_line), .invert(inv),
        .nine(nine), .rx_word(rx_word), .rx_fe(rx_fe),
        .rx_count(rx_count), .low_len(low_len));

    // clock and hang guard
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        $display("errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input bit wr, input logic [3:0] a,
                       input logic [31:0] d);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        // only the hang guard ends a wait that never answers
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wait_frame(input int prev);
        int n;
        n = 0;
        while (rx_count <= prev && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    // status read arms the empty clear, then the data write
    task automatic put(input logic [7:0] b);
        bus(0, A_STA, 32'h0);
        bus(1, A_DAT, {24'h000000, b});
    endtask

    // write a byte and judge what the far end received
    task automatic send(input logic [7:0] b, input logic [8:0] exp);
        int c;
        c = rx_count;
        put(b);
        wait_frame(c);
        chk(rx_word, exp);
        chk(rx_fe, 1'b0);
    endtask

    task automatic t_reset();
        bus(0, A_STA, 32'h0);
        chk(q, 32'h00000003);
        bus(0, A_CTL, 32'h0);
        chk(q, 32'h00000000);
        bus(0, A_BAU, 32'h0);
        chk(q, 32'h00000001);
        bus(1, A_BAU, 32'h00001234);
        bus(0, A_BAU, 32'h0);
        chk(q, 32'h00001234);
        bus(1, A_BAU, 32'h00000001);
        bus(1, 4'h2, 32'h000000ff);
        bus(0, 4'h2, 32'h0);
        chk(q, 32'h00000000);
        chk(tx_out, 1'b1);
        chk(tx_oe, 1'b0);
    endtask

    task automatic t_rxside();
        int n;
        rx_buffer_data <= 8'ha5;
        bus(0, A_DAT, 32'h0);
        chk(q, 32'h000000a5);
        chk(rx_data_read, 1'b1);
        rx_pin <= 1'b0;
        n = 0;
        while (rx_edge_align !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            n++;
        end
        chk(rx_edge_align, 1'b1);
        rx_pin <= 1'b1;
        n = 0;
        while (rx_sample_tick !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        chk(rx_sample_tick, 1'b1);
    endtask

    task automatic t_enable();
        int c;
        bus(1, A_CTL, EN);
        bus(0, A_STA, 32'h0);
        chk(q, 32'h00000005);
        c = rx_count;
        bus(1, A_DAT, 32'h0000005a);
        bus(0, A_STA, 32'h0);
        chk(q, 32'h00000004);
        wait_frame(c);
        chk(rx_word, 9'h05a);
        repeat (32) @(posedge core_clk);
        bus(0, A_STA, 32'h0);
        chk(q, 32'h00000007);
    endtask

    task automatic t_break();
        int lens[4] = '{10, 11, 13, 14};
        int c;
        int n;
        logic [31:0] m;
        for (int k = 0; k < 4; k++) begin
            m = (k[0] ? NINE : 32'h0) | (k[1] ? LBRK : 32'h0);
            nine = k[0];
            c = rx_count;
            bus(1, A_CTL, EN | SEND_BREAK_CONTROL | m);
            bus(1, A_CTL, EN | m);
            wait_frame(c);
            chk(rx_word[7:0], 8'h00);
            chk(rx_fe, 1'b1);
            n = 0;
            while (tx_out !== 1'b1 && n < 400) begin
                @(posedge core_clk);
                n++;
            end
            repeat (2) @(posedge core_clk);
            chk(low_len, 16 * lens[k]);
        end
        nine = 1'b0;
    endtask

    // break control held across a load requeues a second break
    task automatic t_requeue();
        int c;
        bus(1, A_CTL, EN);
        c = rx_count;
        put(8'h11);
        repeat (20) @(posedge core_clk);
        bus(1, A_CTL, EN | SEND_BREAK_CONTROL);
        bus(1, A_CTL, EN);
        bus(1, A_CTL, EN | SEND_BREAK_CONTROL);
        wait_frame(c + 1);
        bus(1, A_CTL, EN);
        while (tx_out !== 1'b1)
            @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        chk(low_len, 32'd320);
    endtask

    task automatic t_invert();
        bus(1, A_CTL, EN | INV);
        repeat (3) @(posedge core_clk);
        chk(tx_out, 1'b0);
        inv = 1'b1;
        send(8'h3c, 9'h03c);
        bus(1, A_CTL, EN);
        repeat (3) @(posedge core_clk);
        inv = 1'b0;
        nine = 1'b1;
        bus(1, A_CTL, EN | NINE | T8);
        send(8'h81, 9'h181);
        nine = 1'b0;
        bus(1, A_CTL, EN);
    endtask

    task automatic t_disable();
        int c;
        logic drop;
        drop = 1'b0;
        c = rx_count;
        put(8'h99);
        repeat (20) @(posedge core_clk);
        bus(1, A_CTL, 32'h0);
        bus(1, A_CTL, EN);
        repeat (200) begin
            @(posedge core_clk);
            if (tx_oe !== 1'b1)
                drop = 1'b1;
        end
        chk(drop, 1'b0);
        chk(rx_word, 9'h099);
        c = rx_count;
        put(8'hc3);
        // disable only once the character's start bit is out
        while (tx_out !== 1'b0)
            @(posedge core_clk);
        bus(1, A_CTL, 32'h0);
        chk(tx_oe, 1'b1);
        wait_frame(c);
        chk(rx_word, 9'h0c3);
        c = 0;
        while (tx_oe !== 1'b0 && c < 200) begin
            @(posedge core_clk);
            c++;
        end
        chk(tx_oe, 1'b0);
    endtask

    // main sequence
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hf;
        rx_buffer_data = 8'h00;
        rx_pin = 1'b1;
        inv = 1'b0;
        nine = 1'b0;
        error_cnt = 0;
        check_count = 0;
        cyc = 0;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_rxside();
        t_enable();
        t_break();
        t_requeue();
        t_invert();
        t_disable();
        summarize();
    end
endmodule
